// file: rtl/t3rc_defs.svh
/*
 * Constants of the Timer 3 reload counter: register indices, byte
 * addresses, reset values, field positions and bus response codes.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef T3RC_DEFS_SVH
`define T3RC_DEFS_SVH

`define T3RC_AXI_AW      12
`define T3RC_AXI_DW      32
`define T3RC_REG_DW      8

`define T3RC_IDX_CTRL    8'hc4
`define T3RC_IDX_LOW     8'hc5
`define T3RC_IDX_HIGH    8'hc6

`define T3RC_ADDR_CTRL   ({2'b00, `T3RC_IDX_CTRL, 2'b00})
`define T3RC_ADDR_LOW    ({2'b00, `T3RC_IDX_LOW, 2'b00})
`define T3RC_ADDR_HIGH   ({2'b00, `T3RC_IDX_HIGH, 2'b00})
`define T3RC_ADDR_STAT   12'h320
`define T3RC_ADDR_MASK   12'h324
`define T3RC_ADDR_COUNT  12'h328

`define T3RC_RST_CTRL    8'h00
`define T3RC_RST_LOW     8'h00
`define T3RC_RST_HIGH    8'h00
`define T3RC_RST_STAT    8'h00
`define T3RC_RST_MASK    8'h00
`define T3RC_RST_COUNT   16'h0000
`define T3RC_CNT_STEP    16'h0001
`define T3RC_CNT_MAX     16'hffff

`define T3RC_STAT_OVF    0
`define T3RC_PS_W        3
`define T3RC_DIV_W       7

`define T3RC_RESP_OKAY   2'b00
`define T3RC_RESP_SLVERR 2'b10

`endif

// file: rtl/t3rc_pkg.sv
/*
 * Types of the Timer 3 reload counter: the control register layout and
 * the register selector produced by address decoding.
 * Assumes t3rc_defs.svh is on the include path.
 */
`include "t3rc_defs.svh"

package t3rc_pkg;

	typedef struct packed {
		logic                   uart1_double_rate;
		logic                   uart1_fe_access_sel;
		logic                   uart0_baud_src_sel;
		logic                   timer3_overflow_flag;
		logic                   timer3_run;
		logic [`T3RC_PS_W-1:0]  timer3_prescale;
	} t3rc_ctrl_t;

	typedef enum logic [6:0] {
		T3RC_SEL_NONE  = 7'b0000001,
		T3RC_SEL_CTRL  = 7'b0000010,
		T3RC_SEL_LOW   = 7'b0000100,
		T3RC_SEL_HIGH  = 7'b0001000,
		T3RC_SEL_STAT  = 7'b0010000,
		T3RC_SEL_MASK  = 7'b0100000,
		T3RC_SEL_COUNT = 7'b1000000
	} t3rc_sel_t;

	typedef enum logic [1:0] {
		T3RC_WS_ACCEPT = 2'b01,
		T3RC_WS_RESP   = 2'b10
	} t3rc_wstate_t;

endpackage : t3rc_pkg

// file: rtl/t3rc_prescaler.sv
/*
 * Power-of-two prescaler producing the Timer 3 count tick.
 * Assumes run, prescale and ce come from logic on core_clk.
 */
`timescale 1ns/10ps
`include "t3rc_defs.svh"

module t3rc_prescaler
	import t3rc_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   run,
	input  wire logic [`T3RC_PS_W-1:0]  prescale,
	output logic                        tick
);

	logic [`T3RC_DIV_W-1:0] div_reg;
	logic [`T3RC_DIV_W-1:0] div_mask;

	// The divider restarts while halted so the first tick after a start
	// always comes a full prescaled period later.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_reg <= '0;
		end else if (ce) begin
			if (!run) begin
				div_reg <= '0;
			end else begin
				div_reg <= div_reg + {{(`T3RC_DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_comb begin
		div_mask = ~({`T3RC_DIV_W{1'b1}} << prescale); // R6
	end

	assign tick = ce & run & ((div_reg & div_mask) == div_mask); // R6

endmodule : t3rc_prescaler

// file: rtl/t3rc_top.sv
/*
 * Timer 3 reload counter with its control and reload registers, the
 * serial port steering bits it carries, an interrupt status and mask,
 * and an AXI4-Lite slave for register access.
 * Assumes every input comes from logic on core_clk; isr_enter is a one
 * cycle pulse from the interrupt controller.
 */
// Overview of operation
// R1 - The overflow flag, control bit 4, is set whenever the counter overflows.
// R2 - Hardware clears the overflow flag when the Timer 3 service routine starts.
// R3 - Software can write the overflow flag to either value directly.
// R4 - Control bit 3 halts the counter at 0 and lets it run at 1.
// R5 - Software writes the reload bytes only while the timer is halted; the reload registers take writes at any time, running or not.
// R6 - Control bits 2:0 divide the count clock by 1 up to 128 in powers of two.
// R7 - The low reload byte is held in a read/write register.
// R8 - The high reload byte is held in a read/write register.
// R9 - Control bit 5 picks Timer 1 at 0 or Timer 3 at 1 as serial port 0 baud.
// R10 - Control bit 7 doubles the serial port 1 rate in Mode 2.
// R11 - Control bit 6 steers serial port 1 bit 7 to mode bit 0 or framing error.
// R12 - The 16-bit counter counts up per tick and reloads on overflow.
`timescale 1ns/10ps
`include "t3rc_defs.svh"

module t3rc_top
	import t3rc_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic [`T3RC_AXI_AW-1:0]  s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [`T3RC_AXI_DW-1:0]  s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`T3RC_AXI_AW-1:0]  s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [`T3RC_AXI_DW-1:0]       s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     isr_enter,
	input  wire logic                     timer1_baud_tick,
	input  wire logic                     uart1_mode_bit0,
	input  wire logic                     uart1_framing_error,
	output logic                          uart0_baud_tick,
	output logic                          uart1_double_rate,
	output logic                          uart1_bit7_to_fe,
	output logic                          uart1_bit7_value,
	output logic                          timer3_overflow_flag,
	output logic                          timer3_overflow_pulse,
	output logic                          irq
);

	function automatic t3rc_sel_t t3rc_decode(
		input logic [`T3RC_AXI_AW-1:0] addr
	);
		t3rc_sel_t sel;
		sel = T3RC_SEL_NONE;
		case (addr)
			`T3RC_ADDR_CTRL:  sel = T3RC_SEL_CTRL;
			`T3RC_ADDR_LOW:   sel = T3RC_SEL_LOW;
			`T3RC_ADDR_HIGH:  sel = T3RC_SEL_HIGH;
			`T3RC_ADDR_STAT:  sel = T3RC_SEL_STAT;
			`T3RC_ADDR_MASK:  sel = T3RC_SEL_MASK;
			`T3RC_ADDR_COUNT: sel = T3RC_SEL_COUNT;
			default:          sel = T3RC_SEL_NONE;
		endcase
		return sel;
	endfunction : t3rc_decode

	t3rc_ctrl_t                 ctrl_reg;
	logic [`T3RC_REG_DW-1:0]    reload_low_reg;
	logic [`T3RC_REG_DW-1:0]    reload_high_reg;
	logic [`T3RC_REG_DW-1:0]    stat_reg;
	logic [`T3RC_REG_DW-1:0]    mask_reg;
	logic [15:0]                count_reg;
	logic                       ovf_pulse_reg;
	logic                       tick;
	logic                       overflow;

	t3rc_wstate_t               wstate_reg;
	logic                       aw_have_reg;
	logic                       w_have_reg;
	logic [`T3RC_AXI_AW-1:0]    aw_addr_reg;
	logic [`T3RC_AXI_DW-1:0]    w_data_reg;
	logic [3:0]                 w_strb_reg;
	logic [1:0]                 bresp_reg;
	logic                       rvalid_reg;
	logic [`T3RC_AXI_DW-1:0]    rdata_reg;
	logic [1:0]                 rresp_reg;

	logic                       aw_fire;
	logic                       w_fire;
	logic                       ar_fire;
	logic                       wr_do;
	logic [`T3RC_AXI_AW-1:0]    wr_addr;
	logic [`T3RC_AXI_DW-1:0]    wr_data;
	logic [3:0]                 wr_strb;
	t3rc_sel_t                  wr_sel;
	t3rc_sel_t                  rd_sel;
	logic                       wr_lane0;
	logic [`T3RC_AXI_DW-1:0]    rd_value;
	t3rc_ctrl_t                 wr_ctrl;

	// Write channel: address and data are taken in either order.
	assign s_axi_awready = ce & (wstate_reg == T3RC_WS_ACCEPT) & ~aw_have_reg;
	assign s_axi_wready  = ce & (wstate_reg == T3RC_WS_ACCEPT) & ~w_have_reg;
	assign s_axi_bvalid  = (wstate_reg == T3RC_WS_RESP);
	assign s_axi_bresp   = bresp_reg;
	assign aw_fire       = s_axi_awvalid & s_axi_awready;
	assign w_fire        = s_axi_wvalid & s_axi_wready;

	assign wr_do   = (wstate_reg == T3RC_WS_ACCEPT) & ce &
	                 (aw_have_reg | aw_fire) & (w_have_reg | w_fire);
	assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb = w_have_reg ? w_strb_reg : s_axi_wstrb;
	assign wr_sel  = t3rc_decode(wr_addr);
	assign wr_lane0 = wr_do & wr_strb[0];
	assign wr_ctrl = t3rc_ctrl_t'(wr_data[`T3RC_REG_DW-1:0]);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wstate_reg  <= T3RC_WS_ACCEPT;
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			bresp_reg   <= `T3RC_RESP_OKAY;
		end else if (ce) begin
			case (wstate_reg)
				T3RC_WS_ACCEPT: begin
					if (wr_do) begin
						aw_have_reg <= 1'b0;
						w_have_reg  <= 1'b0;
						wstate_reg  <= T3RC_WS_RESP;
						bresp_reg   <= (wr_sel == T3RC_SEL_NONE) ?
						               `T3RC_RESP_SLVERR : `T3RC_RESP_OKAY;
					end else begin
						if (aw_fire) begin
							aw_have_reg <= 1'b1;
							aw_addr_reg <= s_axi_awaddr;
						end
						if (w_fire) begin
							w_have_reg <= 1'b1;
							w_data_reg <= s_axi_wdata;
							w_strb_reg <= s_axi_wstrb;
						end
					end
				end
				T3RC_WS_RESP: begin
					if (s_axi_bready) begin
						wstate_reg <= T3RC_WS_ACCEPT;
					end
				end
				default: begin
					wstate_reg <= T3RC_WS_ACCEPT;
				end
			endcase
		end
	end

	// Read channel: one read at a time, data captured on acceptance.
	assign s_axi_arready = ce & ~rvalid_reg;
	assign ar_fire       = s_axi_arvalid & s_axi_arready;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign rd_sel        = t3rc_decode(s_axi_araddr);

	always_comb begin
		rd_value = '0;
		case (rd_sel)
			T3RC_SEL_CTRL:  rd_value[`T3RC_REG_DW-1:0] = ctrl_reg;
			T3RC_SEL_LOW:   rd_value[`T3RC_REG_DW-1:0] = reload_low_reg;
			T3RC_SEL_HIGH:  rd_value[`T3RC_REG_DW-1:0] = reload_high_reg;
			T3RC_SEL_STAT:  rd_value[`T3RC_REG_DW-1:0] = stat_reg;
			T3RC_SEL_MASK:  rd_value[`T3RC_REG_DW-1:0] = mask_reg;
			T3RC_SEL_COUNT: rd_value[15:0] = count_reg;
			default:        rd_value = '0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= `T3RC_RESP_OKAY;
		end else if (ce) begin
			if (ar_fire) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_value;
				rresp_reg  <= (rd_sel == T3RC_SEL_NONE) ?
				              `T3RC_RESP_SLVERR : `T3RC_RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Count tick generation.
	t3rc_prescaler u_prescaler (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.run      (ctrl_reg.timer3_run),
		.prescale (ctrl_reg.timer3_prescale),
		.tick     (tick)
	);

	assign overflow = tick & (count_reg == `T3RC_CNT_MAX); // R12

	// A halted counter keeps its value; it is not cleared by stopping.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_reg <= `T3RC_RST_COUNT;
		end else if (ce && ctrl_reg.timer3_run && tick) begin // R4
			if (overflow) begin
				count_reg <= {reload_high_reg, reload_low_reg}; // R12
			end else begin
				count_reg <= count_reg + `T3RC_CNT_STEP; // R12
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ovf_pulse_reg <= 1'b0;
		end else if (ce) begin
			ovf_pulse_reg <= overflow;
		end
	end

	// Control register. The overflow set outranks every clear in the same
	// cycle so that no overflow is lost.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_reg <= t3rc_ctrl_t'(`T3RC_RST_CTRL);
		end else if (ce) begin
			if (wr_lane0 && wr_sel == T3RC_SEL_CTRL) begin
				ctrl_reg.uart1_double_rate   <= wr_ctrl.uart1_double_rate; // R10
				ctrl_reg.uart1_fe_access_sel <= wr_ctrl.uart1_fe_access_sel; // R11
				ctrl_reg.uart0_baud_src_sel  <= wr_ctrl.uart0_baud_src_sel; // R9
				ctrl_reg.timer3_run          <= wr_ctrl.timer3_run; // R4
				ctrl_reg.timer3_prescale     <= wr_ctrl.timer3_prescale; // R6
			end
			if (overflow) begin
				ctrl_reg.timer3_overflow_flag <= 1'b1; // R1
			end else if (wr_lane0 && wr_sel == T3RC_SEL_CTRL) begin
				ctrl_reg.timer3_overflow_flag <= wr_ctrl.timer3_overflow_flag; // R3
			end else if (isr_enter) begin
				ctrl_reg.timer3_overflow_flag <= 1'b0; // R2
			end
		end
	end

	// Writes while running are stored as given; the counter may pick up a
	// half-updated reload value, which software must avoid.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reload_low_reg  <= `T3RC_RST_LOW;
			reload_high_reg <= `T3RC_RST_HIGH;
		end else if (ce && wr_lane0) begin // R5
			if (wr_sel == T3RC_SEL_LOW) begin
				reload_low_reg <= wr_data[`T3RC_REG_DW-1:0]; // R7
			end
			if (wr_sel == T3RC_SEL_HIGH) begin
				reload_high_reg <= wr_data[`T3RC_REG_DW-1:0]; // R8
			end
		end
	end

	// Interrupt status clears on read; a new overflow in that cycle wins.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stat_reg <= `T3RC_RST_STAT;
		end else if (ce) begin
			if (ar_fire && rd_sel == T3RC_SEL_STAT) begin
				stat_reg <= `T3RC_RST_STAT;
			end
			if (overflow) begin
				stat_reg[`T3RC_STAT_OVF] <= 1'b1; // R1
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mask_reg <= `T3RC_RST_MASK;
		end else if (ce && wr_lane0 && wr_sel == T3RC_SEL_MASK) begin
			mask_reg <= wr_data[`T3RC_REG_DW-1:0];
		end
	end

	assign irq = |(stat_reg & mask_reg);

	// Serial port steering.
	assign uart0_baud_tick = ctrl_reg.uart0_baud_src_sel ?
	                         ovf_pulse_reg : timer1_baud_tick; // R9
	assign uart1_double_rate = ctrl_reg.uart1_double_rate; // R10
	assign uart1_bit7_to_fe  = ctrl_reg.uart1_fe_access_sel; // R11
	assign uart1_bit7_value  = ctrl_reg.uart1_fe_access_sel ?
	                           uart1_framing_error : uart1_mode_bit0; // R11

	assign timer3_overflow_flag  = ctrl_reg.timer3_overflow_flag;
	assign timer3_overflow_pulse = ovf_pulse_reg;

endmodule : t3rc_top

// file: verif/t3rc_chk_chk.sv
/* Port checker of the Timer 3 reload counter.
   Assumes core_clk is the only clock and rst is synchronous. */
`timescale 1ns/10ps
`include "t3rc_defs.svh"
module t3rc_chk
	import t3rc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        isr_enter,
	input wire logic        timer1_baud_tick,
	input wire logic        uart1_mode_bit0,
	input wire logic        uart1_framing_error,
	input wire logic        uart0_baud_tick,
	input wire logic        uart1_double_rate,
	input wire logic        uart1_bit7_to_fe,
	input wire logic        uart1_bit7_value,
	input wire logic        timer3_overflow_flag,
	input wire logic        timer3_overflow_pulse
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_BIT7_MUX: assert property (
		uart1_bit7_value == (uart1_bit7_to_fe ? uart1_framing_error :
		uart1_mode_bit0)) else $error("bit 7 steering wrong");
	AST_BAUD_SRC: assert property (
		uart0_baud_tick |-> timer1_baud_tick || timer3_overflow_pulse)
		else $error("baud tick without source");
	AST_OVF_FLAG: assert property (
		timer3_overflow_pulse |-> timer3_overflow_flag)
		else $error("overflow without flag");
	AST_ISR_CLEAR: assert property (
		isr_enter |=> !timer3_overflow_flag || timer3_overflow_pulse ||
		$rose(s_axi_bvalid)) else $error("flag kept after isr");
	AST_CTRL_WRITE: assert property (
		$changed(uart1_double_rate) || $changed(uart1_bit7_to_fe) |->
		$rose(s_axi_bvalid) || $past(rst)) else $error("ctrl drift");
	AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("write response repeated");
	AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid) else $error("read response repeated");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
endmodule : t3rc_chk

bind t3rc_top t3rc_chk u_chk (.core_clk, .rst, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .isr_enter, .timer1_baud_tick,
	.uart1_mode_bit0, .uart1_framing_error, .uart0_baud_tick,
	.uart1_double_rate, .uart1_bit7_to_fe, .uart1_bit7_value,
	.timer3_overflow_flag, .timer3_overflow_pulse);

// file: verif/t3rc_top_tb.sv
/* Self-checking bench of the Timer 3 reload counter.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/10ps
`include "t3rc_defs.svh"
module t3rc_top_tb
	import t3rc_pkg::*;
;
	logic        core_clk, rst = 1'b1, ce = 1'b1, isr_enter = 1'b0;
	logic        timer1_baud_tick = 1'b1, uart1_mode_bit0 = 1'b1;
	logic        uart1_framing_error = 1'b0, s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, x;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, uart0_baud_tick, uart1_double_rate, irq;
	logic        uart1_bit7_to_fe, uart1_bit7_value;
	logic        timer3_overflow_flag, timer3_overflow_pulse;
	int          fail_count = 0, check_count = 0, cyc = 0, tw, t0;
	// Address, write byte, read byte, response, then the expected
	// double rate, steering select, bit 7 value and baud tick.
	logic [33:0] rows [0:10] = '{
		{12'h310, 8'h00, 8'h00, 2'h0, 4'h3}, {12'h310, 8'h80, 8'h80, 2'h0, 4'hb},
		{12'h310, 8'h40, 8'h40, 2'h0, 4'h5}, {12'h310, 8'h20, 8'h20, 2'h0, 4'h2},
		{12'h310, 8'he7, 8'he7, 2'h0, 4'hc}, {12'h314, 8'ha5, 8'ha5, 2'h0, 4'hc},
		{12'h318, 8'h5a, 8'h5a, 2'h0, 4'hc}, {12'h324, 8'h01, 8'h01, 2'h0, 4'hc},
		{12'h320, 8'hff, 8'h00, 2'h0, 4'hc}, {12'h328, 8'hff, 8'h00, 2'h0, 4'hc},
		{12'h000, 8'hff, 8'h00, 2'h2, 4'hc}};

	t3rc_top DUT (.core_clk, .rst, .ce, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .isr_enter, .timer1_baud_tick, .uart1_mode_bit0,
		.uart1_framing_error, .uart0_baud_tick, .uart1_double_rate,
		.uart1_bit7_to_fe, .uart1_bit7_value, .timer3_overflow_flag,
		.timer3_overflow_pulse, .irq);

	task automatic summarize();
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// Ready is looked at on the falling edge so that the decision never
	// races the slave's own updates on the rising edge.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic pa, pw, ta, tk;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(negedge core_clk);
			ta = pa && s_axi_awready;
			tk = pw && s_axi_wready;
			tw = cyc;
			@(posedge core_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tk)
				s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tk;
		end
		do begin
			@(negedge core_clk);
			ta = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
		end while (!ta);
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge core_clk);
			t = s_axi_arready;
			@(posedge core_clk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge core_clk);
			t = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
		end while (!t);
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// The first overflow needs a full 16-bit count, so the ceiling is
	// set well above 65536 cycles.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 11; i++) begin
			wr(rows[i][33:22], rows[i][21:14]);
			chk("wresp", {30'h0, r}, {30'h0, rows[i][5:4]});
			rd(rows[i][33:22]);
			chk("rresp", {30'h0, r}, {30'h0, rows[i][5:4]});
			chk("rdata", v, {24'h0, rows[i][13:6]});
			chk("outs", {28'h0, uart1_double_rate, uart1_bit7_to_fe,
				uart1_bit7_value, uart0_baud_tick},
				{28'h0, rows[i][3:0]});
		end
		uart1_framing_error <= 1'b1;
		@(posedge core_clk);
		chk("bit7", {31'h0, uart1_bit7_value}, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 3; i++) begin
			rd(12'h310 + 12'(4 * i));
			chk("rstval", v, 32'h0);
		end
		for (int p = 0; p < 8; p++) begin
			rd(12'h328);
			x = v;
			wr(12'h310, 8'h08 | 8'(p));
			t0 = tw;
			repeat (300) @(posedge core_clk);
			wr(12'h310, 8'h00);
			rd(12'h328);
			chk("ticks", v - x, 32'((tw - t0) >> p));
		end
		rd(12'h328);
		x = v;
		wr(12'h310, 8'h08);
		t0 = tw;
		repeat (50) @(posedge core_clk);
		ce <= 1'b0;
		repeat (100) @(posedge core_clk);
		chk("frozen", {31'h0, s_axi_awready}, 32'h0);
		ce <= 1'b1;
		wr(12'h310, 8'h00);
		rd(12'h328);
		chk("freeze", v - x, 32'(tw - t0 - 100));
		wr(12'h314, 8'hfd);
		wr(12'h318, 8'hff);
		wr(12'h324, 8'h00);
		timer1_baud_tick <= 1'b0;
		wr(12'h310, 8'h28);
		while (timer3_overflow_flag !== 1'b1)
			@(negedge core_clk);
		chk("pulse", {31'h0, timer3_overflow_pulse}, 32'h1);
		chk("baud3", {31'h0, uart0_baud_tick}, 32'h1);
		chk("irqmask", {31'h0, irq}, 32'h0);
		@(posedge core_clk);
		wr(12'h310, 8'h00);
		chk("flagclr", {31'h0, timer3_overflow_flag}, 32'h0);
		rd(12'h328);
		chk("reload", {31'h0, v >= 32'hfffd}, 32'h1);
		wr(12'h324, 8'h01);
		chk("irq", {31'h0, irq}, 32'h1);
		rd(12'h320);
		chk("stat", v, 32'h1);
		chk("irqclr", {31'h0, irq}, 32'h0);
		wr(12'h310, 8'h10);
		chk("flagset", {31'h0, timer3_overflow_flag}, 32'h1);
		isr_enter <= 1'b1;
		@(posedge core_clk);
		isr_enter <= 1'b0;
		@(posedge core_clk);
		chk("isr", {31'h0, timer3_overflow_flag}, 32'h0);
		summarize();
	end
endmodule : t3rc_top_tb
